/* design/aso_pkg.sv */
// Package: constants for the analog slave output control block
package aso_pkg;
   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CODE_W = 12;
   localparam int NCH    = 4;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_TRIG_MSK = 8'h04;
   localparam logic [7:0] OFS_STATUS2  = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_PINS     = 8'h14;
   localparam logic [7:0] OFS_RESULT0  = 8'h20;
   // Control register fields
   localparam int CTRL_SW_TRIG = 0;
   localparam int CTRL_HW_EN   = 1;
   // Interrupt status fields
   localparam int IRQ_SCAN  = 0;
   localparam int IRQ_STALE = 1;
   localparam int IRQ_W     = 2;
   // Reset values
   localparam logic [3:0]  TRIG_MSK_RST = 4'h1;
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   localparam logic [1:0]  IRQ_MASK_RST = 2'h0;
   localparam logic [11:0] RESULT_RST   = 12'h000;
   // Code range limits per polarity format
   localparam logic [11:0] UNI_MIN = 12'h000;
   localparam logic [11:0] UNI_MAX = 12'hfff;
   localparam logic [11:0] BIP_MIN = 12'h800;
   localparam logic [11:0] BIP_MAX = 12'h7ff;
   localparam logic [11:0] MID_FLIP = 12'h800;
   // Output data clear value
   localparam logic [3:0] GOUT_CLEAR = 4'h0;
   // Stale watchdog default: 1 ms of silence at 125 MHz
   localparam int STALE_US      = 1000;
   localparam int CLK_MHZ       = 125;
   localparam int STALE_CYC_DEF = STALE_US * CLK_MHZ;
   localparam int STALE_CNT_W   = 20;
   // Scan sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_GAP} aso_state_t;
endpackage

/* design/aso_result_fmt.sv */
// Formats and clamps one raw converter code into the stored result
`timescale 1ns/10ps
module aso_result_fmt
   import aso_pkg::*;
(
   input  wire logic [11:0] raw_code,   // Unipolar code from converter
   input  wire logic        over_range, // Input above reference
   input  wire logic        under_range,// Input below ground
   input  wire logic        unipolar,   // High selects straight binary
   output logic      [11:0] result      // Code to store
);
   // Offset binary to two's complement: flip the top bit
   wire [11:0] bip_code = raw_code ^ MID_FLIP;
   // Extremes of the active format
   wire [11:0] top_code = unipolar ? UNI_MAX : BIP_MAX;
   wire [11:0] bot_code = unipolar ? UNI_MIN : BIP_MIN;
   wire [11:0] fmt_code = unipolar ? raw_code : bip_code;

   // Pick clamped or formatted code
   always_comb
   begin
      if (over_range)
      begin
         result = top_code;
      end
      else if (under_range)
      begin
         result = bot_code;
      end
      else
      begin
         result = fmt_code;
      end
   end
endmodule

/* design/aso_ctrl.sv */
// Top: conversion sequencing, result formatting, stale output handling
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module aso_ctrl
   import aso_pkg::*;
#(
   parameter int STALE_CYCLES = STALE_CYC_DEF   // Silence before data counts as lost
)
(
   input  wire logic              clk,                     // 125 MHz clock
   input  wire logic              rst_n,                   // Synchronous reset
   input  wire logic [ADDR_W-1:0] reg_addr,                // Register byte address
   input  wire logic [DATA_W-1:0] reg_wdata,               // Write data
   input  wire logic              reg_wr,                  // Write strobe
   input  wire logic              reg_rd,                  // Read strobe
   output logic      [DATA_W-1:0] reg_rdata,               // Read data, next cycle
   output logic                   irq,                     // Level interrupt
   input  wire logic              polarity_select_n,       // Strap pin
   input  wire logic              output_clear_on_stale_n, // Strap pin
   input  wire logic [NCH-1:0]    general_inputs,          // Input pins
   output logic      [NCH-1:0]    general_outputs,         // Output pins
   output logic                   output_data_stale,       // Output data lost
   output logic                   conversion_active_n,     // Low while converting
   output logic                   adc_start,               // Start one conversion
   output logic      [1:0]        adc_channel,             // Channel being converted
   input  wire logic [11:0]       adc_code,                // Raw unipolar code
   input  wire logic              adc_over,                // Input above reference
   input  wire logic              adc_under,               // Input below ground
   input  wire logic              adc_done,                // Conversion finished
   input  wire logic              link_up,                 // Link carrying frames
   input  wire logic              link_out_valid,          // New output data pulse
   input  wire logic [NCH-1:0]    link_out_data            // Output data from link
);
   // True for the four legal trigger masks
   function automatic logic mask_ok(input logic [3:0] m);
      mask_ok = (m == 4'h1) || (m == 4'h2) || (m == 4'h4) || (m == 4'h8);
   endfunction

   // Pin synchronisers: first stage read only by second
   logic [1:0]     pol_s1_r, pol_s2_r;     // Strap sync stages
   logic [1:0]     clr_s1_r, clr_s2_r;     // Unused upper bits avoided below
   logic [NCH-1:0] gin_s1_r;               // Input pins, stage one
   logic [NCH-1:0] gin_s2_r;               // Input pins, stage two
   logic [NCH-1:0] gin_d_r;                // Delayed for edge detect
   // Software visible state
   logic [1:0]        ctrl_r;              // Control bits
   logic [3:0]        trig_mask_r;         // Hardware trigger input mask
   logic [IRQ_W-1:0]  irq_stat_r;          // Sticky events
   logic [IRQ_W-1:0]  irq_mask_r;          // Interrupt enables
   logic [11:0]       res_r [NCH];         // Stored results
   logic [DATA_W-1:0] rdata_r;             // Read data register
   logic              irq_r;               // Interrupt output register
   // Sequencer and pins
   aso_state_t        state_r, state_nxt;  // Scan state
   logic [1:0]        ch_r, ch_nxt;        // Current channel
   logic              start_r;             // Start pulse register
   logic              conv_n_r;            // Indicator register
   // Stale handling
   logic [STALE_CNT_W-1:0] idle_cnt_r;     // Cycles since last output data
   logic              stale_r;             // Stale flag register
   logic [NCH-1:0]    gout_r;              // General outputs register

   // Strap and input synchronisers
   always_ff @(posedge clk)
   begin
      pol_s1_r <= {1'b0, polarity_select_n};
      pol_s2_r <= pol_s1_r;
      clr_s1_r <= {1'b0, output_clear_on_stale_n};
      clr_s2_r <= clr_s1_r;
      gin_s1_r <= general_inputs;
      gin_s2_r <= gin_s1_r;
      gin_d_r  <= gin_s2_r;
   end

   wire unipolar  = pol_s2_r[0];                  // High: straight binary
   wire clr_strap = ~clr_s2_r[0];                 // High: clear outputs on stale

   // Register decode
   wire sel_ctrl = (reg_addr == OFS_CTRL);
   wire sel_msk  = (reg_addr == OFS_TRIG_MSK);
   wire sel_st2  = (reg_addr == OFS_STATUS2);
   wire sel_ist  = (reg_addr == OFS_IRQ_STAT);
   wire sel_imk  = (reg_addr == OFS_IRQ_MASK);
   wire sel_pins = (reg_addr == OFS_PINS);
   wire sel_res  = (reg_addr[7:4] == OFS_RESULT0[7:4]) && (reg_addr[1:0] == 2'h0);
   wire [1:0] res_idx = reg_addr[3:2];

   wire sel_in_rise = |(gin_s2_r & ~gin_d_r & trig_mask_r);
   // relies on source holding levels long
   wire hw_trig = ctrl_r[CTRL_HW_EN] & sel_in_rise;
   wire sw_trig = reg_wr & sel_ctrl & reg_wdata[CTRL_SW_TRIG];
   wire trig    = hw_trig | sw_trig;

   // Formatted result of the running conversion
   logic [11:0] fmt_res;
   aso_result_fmt u_fmt
   (
      .raw_code    (adc_code),
      .over_range  (adc_over),
      .under_range (adc_under),
      .unipolar    (unipolar),
      .result      (fmt_res)
   );

   wire conv_end  = (state_r == ST_CONV) & adc_done;
   wire scan_done = conv_end & (ch_r == 2'(NCH - 1));

   // Scan sequencer: channels 0..3 with a one-cycle gap between
   always_comb
   begin
      state_nxt = state_r;
      ch_nxt    = ch_r;
      case (state_r)
         ST_IDLE:
         begin
            if (trig)
            begin
               state_nxt = ST_CONV;
               ch_nxt    = 2'h0;
            end
         end
         ST_CONV:
         begin
            if (scan_done)
            begin
               state_nxt = ST_IDLE;
            end
            else if (adc_done)
            begin
               state_nxt = ST_GAP;
               ch_nxt    = ch_r + 2'h1;
            end
         end
         ST_GAP:
         begin
            state_nxt = ST_CONV;
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers and converter pins
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r  <= ST_IDLE;
         ch_r     <= 2'h0;
         start_r  <= 1'b0;
         conv_n_r <= 1'b1;
      end
      else
      begin
         state_r  <= state_nxt;
         ch_r     <= ch_nxt;
         start_r  <= (state_nxt == ST_CONV) && (state_r != ST_CONV);
         conv_n_r <= (state_nxt != ST_CONV);
      end
   end

   // One result register per channel
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_res
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               res_r[gi] <= RESULT_RST;
            end
            else if (conv_end && (ch_r == 2'(gi)))
            begin
               res_r[gi] <= fmt_res;
            end
         end
      end
   endgenerate

   // Stale watchdog and its edge
   wire silent    = (idle_cnt_r >= STALE_CNT_W'(STALE_CYCLES));
   // stale when link down or silent
   wire stale_nxt = ~link_up | silent;
   wire stale_rise = stale_nxt & ~stale_r;

   // Watchdog counter, stale flag and general outputs
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         idle_cnt_r <= '0;
         stale_r    <= 1'b0;
         gout_r     <= GOUT_CLEAR;
      end
      else
      begin
         stale_r <= stale_nxt;
         if (link_out_valid && link_up)
         begin
            idle_cnt_r <= '0;
            gout_r     <= link_out_data;
         end
         else
         begin
            if (!silent)
            begin
               idle_cnt_r <= idle_cnt_r + 1'b1;
            end
            // clear on stale rise if strapped
            if (stale_rise && clr_strap)
            begin
               gout_r <= GOUT_CLEAR;
            end
         end
      end
   end

   // Event sources for the sticky status bits
   wire [IRQ_W-1:0] ev_set = {stale_rise, scan_done};
   wire [IRQ_W-1:0] ev_clr = (reg_wr & sel_ist) ? reg_wdata[IRQ_W-1:0] : '0;
   wire [3:0] msk_wr = reg_wdata[3:0];

   // Software written registers; set beats clear on status
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl_r      <= CTRL_RST;
         trig_mask_r <= TRIG_MSK_RST;
         irq_stat_r  <= '0;
         irq_mask_r  <= IRQ_MASK_RST;
         irq_r       <= 1'b0;
      end
      else
      begin
         if (reg_wr && sel_ctrl)
         begin
            ctrl_r <= {reg_wdata[CTRL_HW_EN], 1'b0};
         end
         if (reg_wr && sel_msk && mask_ok(msk_wr))
         begin
            trig_mask_r <= msk_wr;
         end
         if (reg_wr && sel_imk)
         begin
            irq_mask_r <= reg_wdata[IRQ_W-1:0];
         end
         irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set;
         irq_r      <= |(((irq_stat_r & ~ev_clr) | ev_set) & irq_mask_r);
      end
   end

   // Read multiplexer
   // status byte two: strap in bit0
   wire [DATA_W-1:0] st2_word = {15'h0000, clr_strap};
   wire [DATA_W-1:0] rd_mux =
      sel_ctrl ? {14'h0000, ctrl_r} :
      sel_msk  ? {12'h000, trig_mask_r} :
      sel_st2  ? st2_word :
      sel_ist  ? {14'h0000, irq_stat_r} :
      sel_imk  ? {14'h0000, irq_mask_r} :
      sel_pins ? {5'h00, conv_n_r, stale_r, unipolar, gout_r, gin_s2_r} :
      sel_res  ? {4'h0, res_r[res_idx]} : '0;

   // Read data stand one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= reg_rd ? rd_mux : '0;
      end
   end

   assign reg_rdata           = rdata_r;
   assign irq                 = irq_r;
   assign general_outputs     = gout_r;
   assign output_data_stale   = stale_r;
   assign conversion_active_n = conv_n_r;
   assign adc_start           = start_r;
   assign adc_channel         = ch_r;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire in_range = ~adc_over & ~adc_under;

   bip_format_a: assert property (
      conv_end && in_range && !unipolar |=> res_r[$past(ch_r)] == ($past(adc_code) ^ 12'h800))
      else $error("bipolar result not two's complement");
   uni_format_a: assert property (
      conv_end && in_range && unipolar |=> res_r[$past(ch_r)] == $past(adc_code))
      else $error("unipolar result not straight binary");
   clamp_high_a: assert property (
      conv_end && adc_over |=> res_r[$past(ch_r)] == ($past(unipolar) ? 12'hfff : 12'h7ff))
      else $error("over-range result not clamped high");
   clamp_low_a: assert property (
      conv_end && !adc_over && adc_under
      |=> res_r[$past(ch_r)] == ($past(unipolar) ? 12'h000 : 12'h800))
      else $error("under-range result not clamped low");
   stale_link_a: assert property (
      !link_up |=> output_data_stale)
      else $error("stale flag low while link down");
   stale_clear_a: assert property (
      $rose(output_data_stale) && $past(clr_strap) |-> general_outputs == 4'h0)
      else $error("outputs not cleared on stale");
   stale_hold_a: assert property (
      $rose(output_data_stale) && !$past(clr_strap)
      |-> general_outputs == $past(general_outputs))
      else $error("outputs changed on stale with hold strap");
   conv_ind_a: assert property (
      (adc_start |-> !conversion_active_n)
      and (!conversion_active_n && !adc_done |=> !conversion_active_n))
      else $error("indicator high during conversion");
   trig_mask_a: assert property (
      mask_ok(trig_mask_r))
      else $error("trigger mask not one-hot");
   status_two_a: assert property (
      reg_rd && sel_st2 |=> reg_rdata == {15'h0000, $past(clr_strap)})
      else $error("status byte two wrong");

   scan_c: cover property (scan_done);
   hw_trig_c: cover property (hw_trig && state_r == ST_IDLE);
   stale_c: cover property ($rose(output_data_stale) && clr_strap);
endmodule

/* bench/aso_adc_model.sv */
// Converter model that answers start pulses with per-channel codes
`timescale 1ns/10ps
module aso_adc_model
(
   input  wire logic        clk,         // Bench clock
   input  wire logic        rst_n,       // Synchronous reset
   input  wire logic        adc_start,   // Start pulse from the block
   input  wire logic [1:0]  adc_channel, // Channel to convert
   input  wire logic        slow,        // Long conversion time
   input  wire logic [47:0] raw_tbl,     // Raw code per channel
   input  wire logic [3:0]  over_tbl,    // Over-range flag per channel
   input  wire logic [3:0]  under_tbl,   // Under-range flag per channel
   output logic      [11:0] adc_code,    // Code, valid only with done
   output logic             adc_over,    // Over-range, valid with done
   output logic             adc_under,   // Under-range, valid with done
   output logic             adc_done     // One-cycle finish pulse
);
   logic       busy_r; // Conversion under way
   logic [3:0] cnt_r;  // Cycles left
   logic [1:0] ch_r;   // Channel latched at start
   // Count down, present results for one cycle, garble them otherwise
   always_ff @(posedge clk)
   begin
      adc_done <= 1'b0;
      adc_code <= ~adc_code;
      adc_over <= ~adc_over;
      adc_under <= ~adc_under;
      if (!rst_n)
      begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         ch_r <= 2'h0;
      end
      else if (adc_start)
      begin
         busy_r <= 1'b1;
         ch_r <= adc_channel;
         cnt_r <= slow ? 4'h9 : 4'h2;
      end
      else if (busy_r && cnt_r == 4'h0)
      begin
         busy_r <= 1'b0;
         adc_done <= 1'b1;
         adc_code <= raw_tbl[ch_r*12 +: 12];
         adc_over <= over_tbl[ch_r];
         adc_under <= under_tbl[ch_r];
      end
      else if (busy_r)
      begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule

/* bench/test_aso_ctrl.sv */
// Self-checking bench for the analog slave output control block
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_aso_ctrl
   import aso_pkg::*;
;
   logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq, slow = 0;
   logic [7:0]  reg_addr = 0;
   logic [15:0] reg_wdata = 0, reg_rdata, d;
   logic        pol_n = 0, clr_n = 0, stale, conv_n, adc_start, adc_over, adc_under;
   logic [3:0]  gin = 0, gout, lod = 0, over_tbl = 4'h4, under_tbl = 4'h8;
   logic        link_up = 1, lov = 0, adc_done;
   logic [1:0]  adc_channel;
   logic [11:0] adc_code;
   logic [47:0] raw_tbl = {12'hfff, 12'h000, 12'hfff, 12'h123};
   int          err_total = 0, cmp_count = 0, cyc = 0, k;
   // Expected results per channel: bipolar then straight binary
   logic [11:0] exp_bip [4] = '{12'h923, 12'h7ff, 12'h7ff, 12'h800};
   logic [11:0] exp_uni [4] = '{12'h123, 12'hfff, 12'hfff, 12'h000};
   always #4 clk = ~clk;
   aso_ctrl #(.STALE_CYCLES(50)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .polarity_select_n(pol_n), .output_clear_on_stale_n(clr_n),
      .general_inputs(gin), .general_outputs(gout), .output_data_stale(stale),
      .conversion_active_n(conv_n), .adc_start(adc_start), .adc_channel(adc_channel),
      .adc_code(adc_code), .adc_over(adc_over), .adc_under(adc_under),
      .adc_done(adc_done), .link_up(link_up), .link_out_valid(lov), .link_out_data(lod));
   aso_adc_model u_adc (.clk(clk), .rst_n(rst_n), .adc_start(adc_start),
      .adc_channel(adc_channel), .slow(slow), .raw_tbl(raw_tbl), .over_tbl(over_tbl),
      .under_tbl(under_tbl), .adc_code(adc_code), .adc_over(adc_over),
      .adc_under(adc_under), .adc_done(adc_done));
   // Print counts and verdict, then stop
   task automatic complete_run();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One write cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One read cycle; data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Wait for a scan to start and finish, checking the indicator
   task automatic wait_scan();
      #1;
      for (k = 0; k < 40 && adc_start !== 1'b1; k++)
         @(posedge clk) #1;
      `CHK(adc_start, 1'b1)
      `CHK(conv_n, 1'b0)
      for (k = 0; k < 100; k++)
      begin
         rd(OFS_IRQ_STAT, d);
         if (d[IRQ_SCAN] === 1'b1)
            break;
      end
      `CHK(d[IRQ_SCAN], 1'b1)
      `CHK(conv_n, 1'b1)
   endtask
   // One link data transfer
   task automatic send(input logic [3:0] v);
      @(posedge clk);
      lov <= 1'b1;
      lod <= v;
      @(posedge clk);
      lov <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // Cycle ceiling against hangs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 70000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and unmapped read
      rd(OFS_TRIG_MSK, d); `CHK(d, 16'h0001)
      rd(OFS_RESULT0, d); `CHK(d, 16'h0000)
      rd(8'h30, d); `CHK(d, 16'h0000)
      rd(OFS_STATUS2, d); `CHK(d, 16'h0001)
      $display("Test reset done");
      // Bipolar scan with the scan interrupt unmasked
      wr(OFS_IRQ_MASK, 16'h0001);
      wr(OFS_CTRL, 16'h0001);
      wait_scan();
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      for (int c = 0; c < 4; c++)
      begin
         rd(OFS_RESULT0 + 8'(4 * c), d); `CHK(d, {4'h0, exp_bip[c]})
      end
      wr(OFS_IRQ_STAT, 16'h0003);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      $display("Test bipolar done");
      // Straight binary, slow converter, interrupt masked
      pol_n <= 1'b1;
      clr_n <= 1'b1;
      slow <= 1'b1;
      wr(OFS_IRQ_MASK, 16'h0000);
      repeat (4) @(posedge clk);
      rd(OFS_STATUS2, d); `CHK(d, 16'h0000)
      wr(OFS_CTRL, 16'h0001);
      wait_scan();
      `CHK(irq, 1'b0)
      for (int c = 0; c < 4; c++)
      begin
         rd(OFS_RESULT0 + 8'(4 * c), d); `CHK(d, {4'h0, exp_uni[c]})
      end
      wr(OFS_IRQ_STAT, 16'h0003);
      $display("Test unipolar done");
      // Trigger masks: invalid refused, each one-hot code kept
      wr(OFS_TRIG_MSK, 16'h0003);
      rd(OFS_TRIG_MSK, d); `CHK(d, 16'h0001)
      for (int b = 3; b >= 0; b--)
      begin
         wr(OFS_TRIG_MSK, 16'(1 << b));
         rd(OFS_TRIG_MSK, d); `CHK(d, 16'(1 << b))
      end
      wr(OFS_TRIG_MSK, 16'h0004);
      wr(OFS_CTRL, 16'h0002);
      // Software trigger bit reads back as zero, enable kept
      rd(OFS_CTRL, d); `CHK(d, 16'h0002)
      // Unselected input must not start a scan
      gin[0] <= 1'b1;
      for (k = 0; k < 30 && adc_start !== 1'b1; k++)
         @(posedge clk) #1;
      `CHK(adc_start, 1'b0)
      // source holds each level over 200 us
      repeat (25001) @(posedge clk);
      gin[2] <= 1'b1;
      wait_scan();
      repeat (25001) @(posedge clk);
      gin <= 4'h0;
      wr(OFS_IRQ_STAT, 16'h0003);
      $display("Test hardware trigger done");
      // Stale with clearing strap, stale interrupt unmasked
      clr_n <= 1'b0;
      wr(OFS_IRQ_MASK, 16'h0002);
      send(4'ha);
      wr(OFS_IRQ_STAT, 16'h0003);
      `CHK(gout, 4'ha)
      `CHK(stale, 1'b0)
      link_up <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(stale, 1'b1)
      `CHK(gout, GOUT_CLEAR)
      `CHK(irq, 1'b1)
      // Pin view: indicator idle, stale, straight binary, outputs and inputs low
      rd(OFS_PINS, d); `CHK(d, 16'h0700)
      // Recovery, then silence with holding strap
      link_up <= 1'b1;
      clr_n <= 1'b1;
      send(4'h5);
      wr(OFS_IRQ_STAT, 16'h0003);
      `CHK(stale, 1'b0)
      `CHK(gout, 4'h5)
      repeat (30) @(posedge clk);
      `CHK(stale, 1'b0)
      repeat (30) @(posedge clk);
      `CHK(stale, 1'b1)
      `CHK(gout, 4'h5)
      $display("Test stale outputs done");
      complete_run();
   end
endmodule
